// File: design/latch_contact_pkg.sv
package latch_contact_pkg;

  localparam int unsigned OPERAND_COUNT = 64;
  localparam int unsigned SEL_WIDTH     = 6;
  localparam int unsigned CLK_HZ        = 100_000_000;
  // coil pulse ceiling before discrepancy is declared, in ms
  localparam int unsigned COIL_TIMEOUT_MS = 50;
  localparam int unsigned COIL_TIMEOUT_CYCLES = (CLK_HZ / 1000) * COIL_TIMEOUT_MS;
  localparam int unsigned TIMER_WIDTH   = 24;

  // register map, word aligned byte offsets
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_EVENTS = 8'h08;

  // config field positions
  localparam int unsigned CFG_CLOSE_LSB = 0;
  localparam int unsigned CFG_OPEN_LSB  = 8;
  localparam int unsigned CFG_PRIO_BIT  = 16;
  localparam int unsigned CFG_EVT_BIT   = 17;
  localparam logic [31:0] CFG_RESET     = 32'h0000_0000;

  typedef enum logic [0:0] {
    PRIO_CLOSE_WINS = 1'b0,
    PRIO_OPEN_WINS  = 1'b1
  } conflict_priority_type;

  typedef enum logic [1:0] {
    ST_STARTUP = 2'b00,
    ST_IDLE    = 2'b01,
    ST_CLOSING = 2'b10,
    ST_OPENING = 2'b11
  } coil_state_type;

endpackage

// File: design/latching_contact_control.sv
`timescale 1ns/1ns
// Summary of operation
// - close request energises close coil, sealed in
// - closed and no open request: ignore close chatter
// - open request energises open coil, sealed in
// - open and no close request: ignore open chatter
// - both requests: priority setting picks outcome
// - read back position at startup before acting
// - readback disagrees with command: declare error
// - error drives fault operand and logs event
// - log each contact change when logging enabled
module latching_contact_control (
  input  wire logic                                        clk_sys,
  input  wire logic                                        rst_n,
  input  wire logic                                        pass_strobe,
  input  wire logic [latch_contact_pkg::OPERAND_COUNT-1:0] operands,
  input  wire logic                                        contact_readback,
  output logic                                             close_coil_q,
  output logic                                             open_coil_q,
  output logic                                             commanded_q,
  output logic                                             latch_fault_q,
  output logic                                             event_pulse_q,
  output logic                                             event_is_fault_q,
  input  wire logic                                        wb_cyc_i,
  input  wire logic                                        wb_stb_i,
  input  wire logic                                        wb_we_i,
  input  wire logic [7:0]                                  wb_adr_i,
  input  wire logic [3:0]                                  wb_sel_i,
  input  wire logic [31:0]                                 wb_dat_i,
  output logic [31:0]                                      wb_dat_o,
  output logic                                             wb_ack_o
);
  import latch_contact_pkg::*;

  logic                   pos_sync;
  logic [31:0]            cfg_q,       cfg_d;
  logic [15:0]            evt_count_q, evt_count_d;
  logic [31:0]            dat_q,       dat_d;
  logic                   ack_q,       ack_d;
  coil_state_type         state_q,     state_d;
  logic                   close_d,     open_d,  cmd_d;
  logic                   fault_d,     evt_d,   evt_fault_d;
  logic [TIMER_WIDTH-1:0] timer_q,     timer_d;
  logic                   pos_prev_q,  pos_prev_d;
  logic                   close_req,   open_req;
  logic [SEL_WIDTH-1:0]   close_sel,   open_sel;
  conflict_priority_type  prio;
  logic                   evt_enable;

  pin_sync u_pos_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pin_in  (contact_readback),
    .level_q (pos_sync)
  );

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign close_sel  = cfg_q[CFG_CLOSE_LSB +: SEL_WIDTH];
  assign open_sel   = cfg_q[CFG_OPEN_LSB +: SEL_WIDTH];
  assign prio       = conflict_priority_type'(cfg_q[CFG_PRIO_BIT]);
  assign evt_enable = cfg_q[CFG_EVT_BIT];
  assign close_req  = operands[close_sel];
  assign open_req   = operands[open_sel];

  // wishbone slave: one wait state, ack drops the cycle after
  always_comb begin
    cfg_d = cfg_q;
    ack_d = 1'b0;
    dat_d = dat_q;
    if (wb_cyc_i && wb_stb_i && !ack_q) begin
      ack_d = 1'b1;
      case (wb_adr_i)
        REG_CONFIG: begin
          dat_d = cfg_q;
          if (wb_we_i) begin
            cfg_d = merge_bytes(cfg_q, wb_dat_i, wb_sel_i);
          end
        end
        REG_STATUS: dat_d = {25'h0, commanded_q, state_q, latch_fault_q, pos_sync,
                             open_coil_q, close_coil_q};
        REG_EVENTS: dat_d = {16'h0, evt_count_q};
        default:    dat_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= CFG_RESET;
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      cfg_q <= cfg_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // coil control: requests evaluated on each protection pass in idle, pulse end checked every cycle, drift every idle cycle without a pass strobe
  always_comb begin
    state_d     = state_q;
    close_d     = close_coil_q;
    open_d      = open_coil_q;
    cmd_d       = commanded_q;
    fault_d     = latch_fault_q;
    timer_d     = timer_q;
    pos_prev_d  = pos_prev_q;
    evt_d       = 1'b0;
    evt_fault_d = 1'b0;
    evt_count_d = evt_count_q;
    if (state_q != ST_STARTUP && timer_q != '0) begin
      timer_d = timer_q - 1'b1;
    end
    case (state_q)
      ST_STARTUP: begin
        if (pass_strobe) begin
          cmd_d      = pos_sync;
          pos_prev_d = pos_sync;
          state_d    = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (pass_strobe) begin
          if (close_req && open_req) begin
            cmd_d = (prio == PRIO_CLOSE_WINS);
          end else if (close_req) begin
            cmd_d = 1'b1;
          end else if (open_req) begin
            cmd_d = 1'b0;
          end
          if (cmd_d && !pos_sync) begin
            close_d = 1'b1;
            timer_d = TIMER_WIDTH'(COIL_TIMEOUT_CYCLES);
            state_d = ST_CLOSING;
          end else if (!cmd_d && pos_sync) begin
            open_d  = 1'b1;
            timer_d = TIMER_WIDTH'(COIL_TIMEOUT_CYCLES);
            state_d = ST_OPENING;
          end else if (pos_sync != cmd_d) begin
            fault_d = 1'b1;
          end
        end
      end
      ST_CLOSING, ST_OPENING: begin
        if (pos_sync == commanded_q) begin
          close_d = 1'b0;
          open_d  = 1'b0;
          fault_d = 1'b0;
          state_d = ST_IDLE;
        end else if (timer_q == '0) begin
          close_d = 1'b0;
          open_d  = 1'b0;
          state_d = ST_IDLE;
          if (!latch_fault_q) begin
            fault_d     = 1'b1;
            evt_d       = 1'b1;
            evt_fault_d = 1'b1;
          end
        end
      end
      default: state_d = ST_STARTUP;
    endcase
    // settled contact moved away from command without a pulse
    if (state_q == ST_IDLE && pos_sync != commanded_q && !latch_fault_q && !pass_strobe) begin
      fault_d     = 1'b1;
      evt_d       = 1'b1;
      evt_fault_d = 1'b1;
    end
    if (state_q != ST_STARTUP && pos_sync != pos_prev_q) begin
      pos_prev_d = pos_sync;
      if (evt_enable && !evt_d) begin
        evt_d = 1'b1;
      end
    end
    if (evt_d) begin
      evt_count_d = evt_count_q + 16'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q          <= ST_STARTUP;
      close_coil_q     <= 1'b0;
      open_coil_q      <= 1'b0;
      commanded_q      <= 1'b0;
      latch_fault_q    <= 1'b0;
      timer_q          <= '0;
      pos_prev_q       <= 1'b0;
      event_pulse_q    <= 1'b0;
      event_is_fault_q <= 1'b0;
      evt_count_q      <= 16'h0;
    end else begin
      state_q          <= state_d;
      close_coil_q     <= close_d;
      open_coil_q      <= open_d;
      commanded_q      <= cmd_d;
      latch_fault_q    <= fault_d;
      timer_q          <= timer_d;
      pos_prev_q       <= pos_prev_d;
      event_pulse_q    <= evt_d;
      event_is_fault_q <= evt_fault_d;
      evt_count_q      <= evt_count_d;
    end
  end
endmodule

// File: design/pin_sync.sv
`timescale 1ns/1ns
module pin_sync (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic pin_in,
  output logic      level_q
);
  logic [2:0] stage_q;
  logic [2:0] stage_d;
  logic       level_d;

  // stage 0 feeds only stage 1; accept once stages 1 and 2 agree
  always_comb begin
    stage_d = {stage_q[1:0], pin_in};
    level_d = (stage_q[2] == stage_q[1]) ? stage_q[2] : level_q;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage_q <= 3'h0;
      level_q <= 1'b0;
    end else begin
      stage_q <= stage_d;
      level_q <= level_d;
    end
  end
endmodule

// File: tb/contact_model.sv
`timescale 1ns/1ns
module contact_model (
  input  wire logic clk_sys,
  input  wire logic close_coil,
  input  wire logic open_coil,
  input  wire logic drift,
  output logic      pos_q
);
  logic [2:0] cnt_q = 3'h0;
  initial pos_q = 1'b1;
  // bistable: keeps position through reset, moves after a few cycles of drive
  always @(posedge clk_sys) begin
    cnt_q <= (close_coil || open_coil) ? cnt_q + 3'h1 : 3'h0;
    if (cnt_q == 3'h4) pos_q <= close_coil;
    if (drift) pos_q <= !pos_q;
  end
endmodule

// File: tb/latching_contact_control_checker.sv
`timescale 1ns/1ns
module latching_contact_control_checker (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic pass_strobe,
  input wire logic contact_readback,
  input wire logic close_coil_q,
  input wire logic open_coil_q,
  input wire logic commanded_q,
  input wire logic event_pulse_q,
  input wire logic event_is_fault_q,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  one_coil_a: assert property (!(close_coil_q && open_coil_q))
    else $error("both coils driven");
  close_cause_a: assert property ($rose(close_coil_q) |-> $past(pass_strobe) && commanded_q)
    else $error("close coil without cause");
  open_cause_a: assert property ($rose(open_coil_q) |-> $past(pass_strobe) && !commanded_q)
    else $error("open coil without cause");
  cmd_hold_a: assert property (!pass_strobe |=> $stable(commanded_q))
    else $error("command moved off pass");
  close_drop_a: assert property (close_coil_q ##0 contact_readback [*6] |=> !close_coil_q)
    else $error("close coil not dropped");
  open_drop_a: assert property (open_coil_q ##0 !contact_readback [*6] |=> !open_coil_q)
    else $error("open coil not dropped");
  fault_evt_a: assert property (event_is_fault_q |-> event_pulse_q)
    else $error("fault flag without event");
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  cover property ($rose(close_coil_q));
  cover property ($rose(open_coil_q));
  cover property (event_is_fault_q);
endmodule

// File: tb/latching_contact_control_tb_top.sv
`timescale 1ns/1ns
module latching_contact_control_tb_top;
  import latch_contact_pkg::*;
  logic                     clk_sys = 1'b0;
  logic                     rst_n = 1'b0;
  logic                     pass_strobe = 1'b0;
  logic                     drift = 1'b0;
  logic [OPERAND_COUNT-1:0] operands = '0;
  logic                     wb_cyc_i = 1'b0;
  logic                     wb_stb_i = 1'b0;
  logic                     wb_we_i = 1'b0;
  logic [7:0]               wb_adr_i = 8'h00;
  logic [3:0]               wb_sel_i = 4'hf;
  logic [31:0]              wb_dat_i = 32'h0;
  logic [31:0]              wb_dat_o, rd;
  logic                     contact_readback, close_coil_q, open_coil_q, commanded_q;
  logic                     latch_fault_q, event_pulse_q, event_is_fault_q, wb_ack_o, mv;
  int                       failures = 0, comparisons = 0, evts = 0, fevts = 0;
  always #5 clk_sys = !clk_sys;
  latching_contact_control DUT (.clk_sys, .rst_n, .pass_strobe, .operands, .contact_readback,
    .close_coil_q, .open_coil_q, .commanded_q, .latch_fault_q, .event_pulse_q,
    .event_is_fault_q, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o);
  contact_model pm (.clk_sys, .close_coil(close_coil_q), .open_coil(open_coil_q), .drift,
    .pos_q(contact_readback));
  always @(posedge clk_sys) begin
    if (event_pulse_q === 1'b1) evts++;
    if (event_is_fault_q === 1'b1) fevts++;
  end
  task automatic print_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= 4'hf;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n == 50) begin
      failures++;
      print_verdict();
    end
    @(posedge clk_sys);
  endtask
  // one evaluation pass with brief requests; waits out any coil drive
  task automatic pass(input logic c, input logic o);
    int n;
    n = 0;
    mv = 1'b0;
    operands[3] <= c;
    operands[5] <= o;
    pass_strobe <= 1'b1;
    @(posedge clk_sys);
    operands <= '0;
    pass_strobe <= 1'b0;
    @(posedge clk_sys);
    while ((close_coil_q || open_coil_q) && n < 40) begin
      mv = 1'b1;
      n++;
      @(posedge clk_sys);
    end
    if (n == 40) begin
      failures++;
      print_verdict();
    end
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic t_start;
    wb(1'b1, REG_CONFIG, 32'h0000_0503);
    wb(1'b0, REG_CONFIG, 32'h0);
    chk(rd, 32'h0000_0503);
    wb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    pass(1'b0, 1'b0);
    chk(commanded_q, 1'b1);
    chk(mv, 1'b0);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(rd, {25'h0, 1'b1, ST_IDLE, 1'b0, 1'b1, 2'b00});
    $display("t_start done");
  endtask
  task automatic t_moves;
    pass(1'b0, 1'b1);
    chk({mv, commanded_q, contact_readback}, 3'h4);
    pass(1'b0, 1'b1);
    chk(mv, 1'b0);
    pass(1'b1, 1'b0);
    chk({mv, commanded_q, contact_readback}, 3'h7);
    pass(1'b1, 1'b0);
    chk(mv, 1'b0);
    $display("t_moves done");
  endtask
  task automatic t_prio;
    for (int p = 1; p >= 0; p--) begin
      wb(1'b1, REG_CONFIG, 32'h0000_0503 | (p << CFG_PRIO_BIT));
      pass(1'b1, 1'b1);
      chk({mv, commanded_q}, {1'b1, p == 0});
    end
    $display("t_prio done");
  endtask
  task automatic t_evt;
    chk(evts, 0);
    wb(1'b1, REG_CONFIG, 32'h0002_0503);
    pass(1'b0, 1'b1);
    chk(evts, 1);
    wb(1'b0, REG_EVENTS, 32'h0);
    chk(rd, 32'h1);
    $display("t_evt done");
  endtask
  task automatic t_drift;
    int n;
    drift <= 1'b1;
    @(posedge clk_sys);
    drift <= 1'b0;
    for (n = 0; n < 20 && latch_fault_q !== 1'b1; n++) @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
    chk(latch_fault_q, 1'b1);
    chk(fevts, 1);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(rd, {25'h0, 1'b0, ST_IDLE, 1'b1, 1'b1, 2'b00});
    wb(1'b0, REG_EVENTS, 32'h0);
    chk(rd, 32'h2);
    $display("t_drift done");
  endtask
  // request wiring as the controlling logic outside the block would make it
  task automatic t_follow;
    logic s;
    s = 1'b0;
    pass(s, !s);
    chk({mv, commanded_q, contact_readback, latch_fault_q}, 4'h8);
    s = 1'b1;
    pass(s, !s);
    chk({mv, commanded_q, contact_readback, latch_fault_q}, 4'he);
    wb(1'b1, REG_CONFIG, 32'h0000_0305);
    pass(1'b1, 1'b0);
    chk({mv, commanded_q, contact_readback}, 3'h4);
    wb(1'b1, REG_CONFIG, 32'h0000_0503);
    pass(1'b1, 1'b0);
    chk({mv, commanded_q, contact_readback}, 3'h7);
    // open request held back; a stand-in for the 20 ms pickup to keep the run short
    repeat (20) @(posedge clk_sys);
    pass(1'b0, 1'b1);
    chk({mv, commanded_q, contact_readback}, 3'h4);
    $display("t_follow done");
  endtask
  // second reset with the contact closed: startup must read it back
  task automatic t_reset;
    pass(1'b1, 1'b0);
    chk({mv, commanded_q, contact_readback}, 3'h7);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    chk({close_coil_q, open_coil_q, commanded_q, latch_fault_q}, 4'h0);
    repeat (5) @(posedge clk_sys);
    pass(1'b0, 1'b0);
    chk({mv, commanded_q, latch_fault_q}, 3'h2);
    $display("t_reset done");
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    t_start();
    t_moves();
    t_prio();
    t_evt();
    t_drift();
    t_follow();
    t_reset();
    print_verdict();
  end
endmodule
bind latching_contact_control latching_contact_control_checker chk_i (.clk_sys, .rst_n,
  .pass_strobe, .contact_readback, .close_coil_q, .open_coil_q, .commanded_q,
  .event_pulse_q, .event_is_fault_q, .wb_cyc_i, .wb_stb_i, .wb_ack_o);
